// File: verilog/timer_defs.svh
// Constants for the eight-bit reload event timer: register indices,
// reset values, field positions and prescaler tap masks.
// Assumes inclusion by bare name from the package and the timer module.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// Register indices; the byte address on the bus is four times the index
`define IDX_MODE 16'hFFB2
`define IDX_COUNT 16'hFFB3
`define IDX_STATUS 16'hFFC0
`define IDX_MASK 16'hFFC1
`define IDX_EDGE 16'hFFC2
`define ADDR_W 18
`define DATA_W 32

// Reset values and fixed fields
`define MODE_RESET 8'h78
`define RELOAD_BIT_RESET 1'b0
`define SRC_RESET 3'h0
`define MODE_RSVD 8'h78
`define COUNT_RESET 8'h00
`define RELOAD_RESET 8'h00
`define COUNT_MAX 8'hFF
`define BIT_RELOAD 7
`define SRC_MSB 2
`define BIT_OVF 0
`define BIT_EDGE 0

// Count source codes
`define SRC_DIV8192 3'h0
`define SRC_DIV2048 3'h1
`define SRC_DIV512 3'h2
`define SRC_DIV256 3'h3
`define SRC_DIV64 3'h4
`define SRC_DIV16 3'h5
`define SRC_DIV4 3'h6
`define SRC_EXT 3'h7

// Prescaler width and the low-bit masks that mark each tap's last cycle
`define PRE_W 13
`define PRE_ONE 13'h0001
`define MASK_8192 13'h1FFF
`define MASK_2048 13'h07FF
`define MASK_512 13'h01FF
`define MASK_256 13'h00FF
`define MASK_64 13'h003F
`define MASK_16 13'h000F
`define MASK_4 13'h0003

`endif

// File: verilog/timer_pkg.sv
// Types shared by the reload event timer.
// Assumes the constants header is on the include path.
`include "timer_defs.svh"

package timer_pkg;

  // Software-visible fields of the mode register
  typedef struct packed {
    logic reload_mode_select;
    logic [`SRC_MSB:0] count_source_select;
  } mode_fields_t;

  // Bus handshake states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACCESS = 2'b10
  } bus_state_t;

endpackage

// File: verilog/reload_event_timer.sv
// Eight-bit up-counting timer with interval and auto-reload modes,
// prescaled or external-edge count source, and an APB register slave.
// Assumes APB inputs and the event pin are synchronous to CORE_CLK_IN.
//
// Notes on behaviour
// RL1: The mode bit selects interval counting at 0 (reset) and auto-reload at 1.
// RL2: Mode bits 6 to 3 always read 1 and ignore writes.
// RL3: The source field picks clock/8192, /2048, /512, /256, /64, /16, /4 or the event pin.
// RL4: Event counting uses the rising or falling pin edge chosen by a separate edge bit.
// RL5: Software sets the pin function bit before choosing the event pin as source.
// RL6: The count is read-only, steps by one per source pulse and is readable at any time.
// RL7: Stepping past FF, by wrap or by reload, sets the overflow flag.
// RL8: An interrupt is requested while the flag is set and its enable is 1.
// RL9: Count and reload share one address; reads give the count, writes the reload.
// RL10: Reset clears count, reload and mode bit so interval counting starts at once.
// RL11: Writing the reload value also copies it into the count in either mode.
// RL12: Interval mode wraps to 00 on overflow, one overflow per 256 pulses.
// RL13: Auto-reload mode loads the reload value on overflow, a period of 1 to 256 pulses.
// RL14: Software masks the pin's own external interrupt when it counts events.
// RL15: The count halts in the low-power halt states while the mode register keeps its value.
// RL16: The overflow flag stays set until software clears it, whatever overflows follow.
// RL17: The mode register resets to 78 with mode bit and source field clear.
`include "timer_defs.svh"

module reload_event_timer
  import timer_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [`ADDR_W-1:0] PADDR_IN,
  input wire logic [`DATA_W-1:0] PWDATA_IN,
  output logic [`DATA_W-1:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic EVENT_INPUT_PIN_IN,
  input wire logic LOW_POWER_HALT_IN,
  output logic IRQ_OUT
);

  // Tick of the selected prescaler tap: high in the last cycle of each period
  function automatic logic tap_tick(input logic [`SRC_MSB:0] sel, input logic [`PRE_W-1:0] pre);
    logic [`PRE_W-1:0] m;
    m = '0;
    case (sel)
      `SRC_DIV8192: m = `MASK_8192;
      `SRC_DIV2048: m = `MASK_2048;
      `SRC_DIV512: m = `MASK_512;
      `SRC_DIV256: m = `MASK_256;
      `SRC_DIV64: m = `MASK_64;
      `SRC_DIV16: m = `MASK_16;
      `SRC_DIV4: m = `MASK_4;
      default: m = '0;
    endcase
    return (sel != `SRC_EXT) && ((pre & m) == m);
  endfunction

  // Word-aligned register match
  function automatic logic addr_is(input logic [`ADDR_W-1:0] a, input logic [15:0] idx);
    return a == {idx, 2'b00};
  endfunction

  logic rst_meta_q;
  logic rst_n;
  bus_state_t state_q;
  mode_fields_t mode_q;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [7:0] reload_q;
  logic edge_sel_q;
  logic status_q;
  logic status_d;
  logic mask_q;
  logic evt_prev_q;
  logic [`PRE_W-1:0] pre_q;
  logic pready_q;
  logic [`DATA_W-1:0] prdata_q;
  logic pslverr_q;
  logic irq_q;

  // Reset release through two flops; the first feeds only the second
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // Address decode
  wire sel_mode = addr_is(PADDR_IN, `IDX_MODE);
  wire sel_count = addr_is(PADDR_IN, `IDX_COUNT);
  wire sel_status = addr_is(PADDR_IN, `IDX_STATUS);
  wire sel_mask = addr_is(PADDR_IN, `IDX_MASK);
  wire sel_edge = addr_is(PADDR_IN, `IDX_EDGE);
  wire addr_hit = sel_mode | sel_count | sel_status | sel_mask | sel_edge;

  // Setup is seen in idle; the access completes on the edge with pready high
  wire setup = (state_q == ST_IDLE) && PSEL_IN && !PENABLE_IN;
  wire acc = (state_q == ST_ACCESS) && PSEL_IN && PENABLE_IN && pready_q;
  wire wr_ok = acc && PWRITE_IN && addr_hit;
  wire wr_mode = wr_ok && sel_mode;
  wire wr_reload = wr_ok && sel_count; // RL9
  wire wr_mask = wr_ok && sel_mask;
  wire wr_edge = wr_ok && sel_edge;
  wire rd_status = acc && !PWRITE_IN && sel_status;
  // Enable as it stands after this edge, so the request follows a mask write at once
  wire mask_d = wr_mask ? PWDATA_IN[`BIT_OVF] : mask_q;

  // Read view; reserved mode bits forced to one
  wire [7:0] mode_rd = {mode_q.reload_mode_select, 4'h0, mode_q.count_source_select} | `MODE_RSVD; // RL2
  wire [7:0] rd_byte = sel_mode ? mode_rd :
                       sel_count ? count_q : // RL9
                       sel_status ? {7'h00, status_q} :
                       sel_mask ? {7'h00, mask_q} :
                       sel_edge ? {7'h00, edge_sel_q} : 8'h00;

  // Source pulses: prescaler tap or chosen pin edge, gated by halt
  wire evt_rise = EVENT_INPUT_PIN_IN && !evt_prev_q;
  wire evt_fall = !EVENT_INPUT_PIN_IN && evt_prev_q;
  wire evt_edge = edge_sel_q ? evt_rise : evt_fall; // RL4
  wire is_ext = mode_q.count_source_select == `SRC_EXT;
  wire src_pulse = is_ext ? evt_edge : tap_tick(mode_q.count_source_select, pre_q); // RL3
  wire tick = src_pulse && !LOW_POWER_HALT_IN; // RL15
  wire ovf = tick && (count_q == `COUNT_MAX) && !wr_reload; // RL7

  // Next count: a reload write wins over a tick in the same cycle
  always_comb begin
    count_d = count_q;
    if (wr_reload) begin
      count_d = PWDATA_IN[7:0]; // RL11
    end else if (ovf) begin
      count_d = mode_q.reload_mode_select ? reload_q : `COUNT_RESET; // RL1 RL12 RL13
    end else if (tick) begin
      count_d = count_q + 8'h01; // RL6
    end
  end

  // Overflow flag: set wins over the read clear
  assign status_d = ovf | (status_q & !rd_status); // RL16

  // Bus handshake: pready is raised for the first access cycle
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      pready_q <= 1'b0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (setup) begin
            state_q <= ST_ACCESS;
            pready_q <= 1'b1;
            prdata_q <= {24'h00_0000, rd_byte};
            pslverr_q <= !addr_hit;
          end
        end
        ST_ACCESS: begin
          if (acc || !PSEL_IN) begin
            state_q <= ST_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          pready_q <= 1'b0;
        end
      endcase
    end
  end

  // Software registers; mode keeps its value through halt states
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= '{`RELOAD_BIT_RESET, `SRC_RESET}; // RL10 RL17
      reload_q <= `RELOAD_RESET; // RL10
      mask_q <= 1'b0;
      edge_sel_q <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_q <= mode_fields_t'({PWDATA_IN[`BIT_RELOAD], PWDATA_IN[`SRC_MSB:0]}); // RL1 RL2
      end
      if (wr_reload) begin
        reload_q <= PWDATA_IN[7:0]; // RL9
      end
      if (wr_mask) begin
        mask_q <= PWDATA_IN[`BIT_OVF];
      end
      if (wr_edge) begin
        edge_sel_q <= PWDATA_IN[`BIT_EDGE]; // RL4
      end
    end
  end

  // Counter, prescaler, pin history, flag and interrupt line
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= `COUNT_RESET; // RL10
      pre_q <= '0;
      evt_prev_q <= 1'b0;
      status_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      count_q <= count_d;
      pre_q <= LOW_POWER_HALT_IN ? pre_q : pre_q + `PRE_ONE;
      evt_prev_q <= EVENT_INPUT_PIN_IN;
      status_q <= status_d; // RL7
      irq_q <= status_d & mask_d; // RL8
    end
  end

  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = pready_q;
  assign PSLVERR_OUT = pslverr_q;
  assign IRQ_OUT = irq_q;

  // Checks on the block's own behaviour
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!rst_n);

  sequence s_wrap;
    ovf && !mode_q.reload_mode_select;
  endsequence

  sequence s_reload;
    ovf && mode_q.reload_mode_select;
  endsequence

  sequence s_setup_mode_rd;
    setup && sel_mode && !PWRITE_IN;
  endsequence

  property p_interval_wrap;
    s_wrap |=> count_q == `COUNT_RESET;
  endproperty
  a_interval_wrap: assert property (p_interval_wrap) else $error("interval wrap not to zero"); // RL12

  property p_auto_reload;
    logic [7:0] r;
    (s_reload, r = reload_q) |=> count_q == r;
  endproperty
  a_auto_reload: assert property (p_auto_reload) else $error("reload value not loaded"); // RL13

  property p_reserved_read;
    s_setup_mode_rd |=> PREADY_OUT && PRDATA_OUT[6:3] == 4'hF;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bits not read as one"); // RL2

  property p_step;
    (tick && !ovf && !wr_reload) |=> count_q == $past(count_q) + 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("counter did not step by one"); // RL6

  property p_hold;
    (!tick && !wr_reload) |=> $stable(count_q);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved without a pulse"); // RL6

  property p_flag_set;
    ovf |=> status_q ##1 (status_q || $past(rd_status));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("overflow flag not set"); // RL7

  property p_flag_sticky;
    (status_q && !rd_status) |=> status_q;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("overflow flag lost"); // RL16

  property p_irq;
    (status_q && mask_q) |-> IRQ_OUT;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised"); // RL8

  property p_irq_masked;
    !mask_q |-> !IRQ_OUT;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked interrupt raised"); // RL8

  property p_write_copy;
    wr_reload |=> count_q == $past(PWDATA_IN[7:0]) && reload_q == count_q;
  endproperty
  a_write_copy: assert property (p_write_copy) else $error("write not copied to count"); // RL11

  property p_halt;
    (LOW_POWER_HALT_IN && !wr_reload) |=> $stable(count_q);
  endproperty
  a_halt: assert property (p_halt) else $error("counter ran while halted"); // RL15

  property p_div4;
    (mode_q.count_source_select == `SRC_DIV4 && tick) |=> !tick [*3];
  endproperty
  a_div4: assert property (p_div4) else $error("clock/4 tap too fast"); // RL3

  property p_ext_edge;
    (is_ext && !LOW_POWER_HALT_IN) |-> tick == (edge_sel_q ? evt_rise : evt_fall);
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("wrong event edge counted"); // RL4

  property p_reset_start;
    $rose(rst_n) |-> count_q == `COUNT_RESET && reload_q == `RELOAD_RESET && mode_rd == `MODE_RESET;
  endproperty
  a_reset_start: assert property (p_reset_start) else $error("reset values wrong"); // RL10 RL17

  property p_shared_addr;
    (setup && sel_count && !PWRITE_IN) |=> PRDATA_OUT[7:0] == $past(count_q);
  endproperty
  a_shared_addr: assert property (p_shared_addr) else $error("count read wrong"); // RL9

  property p_ready_one;
    setup |=> PREADY_OUT ##1 !PREADY_OUT;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready not one cycle"); // RL9

endmodule

// File: testbench/event_source.sv
// Partner model: the external event signal source on the event pin.
// Assumes the bench calls its tasks; levels change just after rising edges.
module event_source (
  input wire logic clk_in,
  output logic pin_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial pin_out = 1'b0;

  // Set a level after an edge and hold it so the design sees it settle
  task automatic drive(input logic v);
    @(posedge clk_in);
    pin_out <= v;
    repeat (2) @(posedge clk_in);
  endtask

  // Whole pulses, each one rising and one falling edge
  task automatic pulses(input int n);
    repeat (n) begin
      drive(1'b1);
      drive(1'b0);
    end
  endtask
endmodule

// File: testbench/test_eight_bit_reload_event_timer.sv
// Self-checking bench for the reload event timer over APB.
// Assumes the constants header on the include path and the event_source model.
`include "timer_defs.svh"

module test_eight_bit_reload_event_timer;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic halt;
  logic [`ADDR_W-1:0] paddr;
  logic [`DATA_W-1:0] pwdata;
  logic [`DATA_W-1:0] prdata;
  logic [`DATA_W-1:0] r;
  logic pready, pslverr, irq, pin, e;
  int errors = 0;
  int n_compared = 0;

  initial clk = 1'b0;
  always #5 clk = ~clk;

  reload_event_timer reload_event_timer_inst (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .EVENT_INPUT_PIN_IN(pin), .LOW_POWER_HALT_IN(halt),
    .IRQ_OUT(irq));
  event_source event_source_inst (.clk_in(clk), .pin_out(pin));

  // Comparisons
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // One APB transfer; answer taken at the rising edge that samples pready high, released there
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk_bit(pready, 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
    chk_bit(e, 1'b0);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(r, {24'h00_0000, exp});
  endtask

  // Interrupt level once the one-cycle lag has passed
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk_bit(irq, exp);
  endtask

  task automatic conclude;
    $display("Comparisons %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of a few hundred cycles
  initial begin
    #200000;
    errors++;
    conclude();
  end

  // Main sequence
  initial begin
    logic [7:0] c0;
    logic [7:0] dlt;
    rst_n <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    halt <= 1'b0;
    paddr <= '0;
    pwdata <= '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`IDX_MODE, 8'h78);
    rd(`IDX_COUNT, 8'h00);
    rd(`IDX_STATUS, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(`IDX_MODE, 8'(i));
      rd(`IDX_MODE, 8'h78 | 8'(i));
    end
    wr(`IDX_MODE, 8'h07);
    rd(`IDX_MODE, 8'h7F);
    wr(`IDX_MASK, 8'h01);
    wr(`IDX_COUNT, 8'hFE);
    rd(`IDX_COUNT, 8'hFE);
    event_source_inst.pulses(1);
    rd(`IDX_COUNT, 8'hFF);
    irq_is(1'b0);
    event_source_inst.pulses(1);
    irq_is(1'b1);
    rd(`IDX_COUNT, 8'h00);
    wr(`IDX_COUNT, 8'hFF);
    event_source_inst.pulses(1);
    rd(`IDX_STATUS, 8'h01);
    rd(`IDX_STATUS, 8'h00);
    irq_is(1'b0);
    // Auto-reload: three pulses from FD come back to FD
    wr(`IDX_MODE, 8'h87);
    rd(`IDX_MODE, 8'hFF);
    wr(`IDX_COUNT, 8'hFD);
    event_source_inst.pulses(3);
    rd(`IDX_COUNT, 8'hFD);
    rd(`IDX_STATUS, 8'h01);
    // Rising edge counts, falling edge does not
    wr(`IDX_EDGE, 8'h01);
    event_source_inst.drive(1'b1);
    rd(`IDX_COUNT, 8'hFE);
    event_source_inst.drive(1'b0);
    rd(`IDX_COUNT, 8'hFE);
    // Halted: no counting, mode kept
    halt <= 1'b1;
    event_source_inst.pulses(1);
    rd(`IDX_COUNT, 8'hFE);
    rd(`IDX_MODE, 8'hFF);
    halt <= 1'b0;
    // Masked overflow raises the flag but no request
    wr(`IDX_MASK, 8'h00);
    wr(`IDX_COUNT, 8'hFF);
    event_source_inst.drive(1'b1);
    irq_is(1'b0);
    rd(`IDX_COUNT, 8'hFF);
    rd(`IDX_STATUS, 8'h01);
    event_source_inst.drive(1'b0);
    // Unmapped address is refused
    apb(1'b0, 16'hFF00, 8'h00);
    chk_bit(e, 1'b1);
    chk(r, 32'h0000_0000);
    // Clock/4 tap: about ten steps in forty cycles
    wr(`IDX_MODE, 8'h06);
    apb(1'b0, `IDX_COUNT, 8'h00);
    c0 = r[7:0];
    repeat (40) @(posedge clk);
    apb(1'b0, `IDX_COUNT, 8'h00);
    dlt = r[7:0] - c0;
    chk_bit(dlt >= 8'd10 && dlt <= 8'd14, 1'b1);
    conclude();
  end
endmodule
